// ### inc/ims_pkg.sv
// Shared constants and types of the two-wire master segment engine.
package ims_pkg;
    // Command bit positions in the segment command register.
    localparam int CMD_START = 0;
    localparam int CMD_SEND = 1;
    localparam int CMD_RECV = 2;
    localparam int CMD_STOP = 3;
    localparam logic [3:0] CMD_RST = 4'h0;
    // Status flag positions in the bus status register.
    localparam int FLG_CMDFIN = 0;
    localparam int FLG_TXFIN = 1;
    localparam int FLG_RXFIN = 2;
    localparam int FLG_NACK = 3;
    localparam logic [3:0] FLG_RST = 4'h0;
    // Controller function select value that enables the two-wire master.
    localparam logic [2:0] MODE_I2C = 3'h3;
    localparam logic [7:0] DATA_RST = 8'h00;
    // Bus timing: one quarter of an SCL period at 100 kbit/s.
    localparam int CLK_NS = 8;
    localparam int QTR_NS = 2500;
    localparam int QTR_CYCLES = (QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 16;
    // Depth of the receive character buffer.
    localparam int RXBUF_DEPTH = 2;
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} ims_state_type;
endpackage

// ### src/ims_pair_buffer.sv
// Small shift-style FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ims_pair_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [DEPTH-1:0] vld_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic [CW-1:0] wpos;
    logic push;
    logic pop;

    // Entry zero is always the head, so the outputs come straight from flops.
    assign push = in_valid_i && !vld_r[DEPTH-1];
    assign pop = vld_r[0] && out_ready_i;
    assign wpos = pop ? cnt_r - CW'(1) : cnt_r;
    assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    assign in_ready_o = !vld_r[DEPTH-1];
    assign out_valid_o = vld_r[0];
    assign out_data_o = mem_r[0];

    // Storage moves down on a pop; a push lands behind the last live entry.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= '0;
            vld_r <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            cnt_r <= cnt_nxt;
            for (int i = 0; i < DEPTH; i++) begin
                vld_r[i] <= (CW'(i) < cnt_nxt);
                if (push && CW'(i) == wpos) begin
                    mem_r[i] <= in_data_i;
                end else if (pop && i < DEPTH - 1) begin
                    mem_r[i] <= mem_r[i+1];
                end
            end
        end
    end
endmodule

// ### src/ims_segment_master.sv
// Two-wire bus master that generates start, transmit, receive and stop segments.
// Functional notes
// - One command bit launches each bus segment.
// - Start bit issues start or repeated start.
// - Send shifts eight bits MSB first, samples acknowledge.
// - Receive clocks in a byte, drives acknowledge.
// - Stop bit issues a stop condition.
// - No command bit means bus left untouched.
// - Receive acknowledge level follows ack select.
// - One shared character register for both directions.
// - Start and stop bits self-clear when done.
// - Start or stop completion sets command-finished flag.
// - Send bit clears and transmit-finished flag sets.
// - Receive bit clears, receive-finished flag sets.
// - Transmit records slave NACK or ACK.
// - SCL and SDA are open-drain outputs.
// - Single master, enabled by function select three.
`timescale 1ns/1ps
module ims_segment_master #(
    parameter int QTR_CYCLES_P = ims_pkg::QTR_CYCLES
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic [2:0] MODE_I,
    input wire logic [3:0] CMD_SET_I,
    output logic [3:0] CMD_O,
    input wire logic ACK_SELECT_I,
    input wire logic [3:0] FLAG_CLR_I,
    output logic [3:0] FLAGS_O,
    input wire logic DATA_WR_I,
    input wire logic [7:0] DATA_I,
    output logic [7:0] DATA_O,
    output logic RX_VALID_O,
    input wire logic RX_READY_I,
    output logic [7:0] RX_DATA_O,
    output logic BUSY_O,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE_O,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O
);
    ims_pkg::ims_state_type state_r;
    logic [ims_pkg::CNT_W-1:0] cnt_r;
    logic [1:0] phase_r;
    logic [3:0] bit_idx_r;
    logic [8:0] shift_r;
    logic [8:0] rx_shift_r;
    logic is_tx_r;
    logic is_rx_r;
    logic ack_sel_r;
    logic [3:0] cmd_r;
    logic [3:0] flag_r;
    logic [7:0] char_r;
    logic scl_oe_r;
    logic sda_oe_r;
    logic scl_oe_nxt;
    logic sda_oe_nxt;
    logic scl_s1_r;
    logic scl_s2_r;
    logic sda_s1_r;
    logic sda_s2_r;
    logic need_high;
    logic adv;
    logic done;
    logic launch;
    logic mode_ok;
    logic one_cmd;
    logic buf_ready;
    logic rx_push;
    logic busy_r;

    // Pins come from the bus and pass two flops before any logic reads them.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
        end else begin
            scl_s1_r <= SCL_I;
            scl_s2_r <= scl_s1_r;
            sda_s1_r <= SDA_I;
            sda_s2_r <= sda_s1_r;
        end
    end

    // Bit phases 1 and 2 and start or stop phase 1 end only once SCL really reads high, which honours slave clock stretching.
    assign need_high = (state_r == ims_pkg::ST_BIT && (phase_r == 2'h1 || phase_r == 2'h2)) ||
        ((state_r == ims_pkg::ST_START || state_r == ims_pkg::ST_STOP) && phase_r == 2'h1);
    assign adv = (state_r != ims_pkg::ST_IDLE) && (cnt_r == ims_pkg::CNT_W'(QTR_CYCLES_P - 1)) &&
        !(need_high && !scl_s2_r);
    assign done = adv && phase_r == 2'h3 && (state_r != ims_pkg::ST_BIT || bit_idx_r == 4'h8);
    assign mode_ok = (MODE_I == ims_pkg::MODE_I2C);
    assign one_cmd = $onehot(cmd_r);
    // A receive waits for buffer room so that a stalled reader never loses a character.
    assign launch = (state_r == ims_pkg::ST_IDLE) && mode_ok && one_cmd &&
        (!cmd_r[ims_pkg::CMD_RECV] || buf_ready);
    assign rx_push = done && is_rx_r;

    // Segment sequencer: four quarter-period phases per start, stop or bit.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_r <= ims_pkg::ST_IDLE;
            cnt_r <= '0;
            phase_r <= 2'h0;
            bit_idx_r <= 4'h0;
            is_tx_r <= 1'b0;
            is_rx_r <= 1'b0;
            ack_sel_r <= 1'b0;
        end else if (launch) begin
            cnt_r <= '0;
            phase_r <= 2'h0;
            bit_idx_r <= 4'h0;
            is_tx_r <= cmd_r[ims_pkg::CMD_SEND];
            is_rx_r <= cmd_r[ims_pkg::CMD_RECV];
            ack_sel_r <= ACK_SELECT_I;
            if (cmd_r[ims_pkg::CMD_START]) begin
                state_r <= ims_pkg::ST_START;
            end else if (cmd_r[ims_pkg::CMD_STOP]) begin
                state_r <= ims_pkg::ST_STOP;
            end else begin
                state_r <= ims_pkg::ST_BIT;
            end
        end else if (state_r != ims_pkg::ST_IDLE) begin
            if (!adv) begin
                if (cnt_r != ims_pkg::CNT_W'(QTR_CYCLES_P - 1)) begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end else begin
                cnt_r <= '0;
                phase_r <= phase_r + 2'h1;
                if (done) begin
                    state_r <= ims_pkg::ST_IDLE;
                end else if (phase_r == 2'h3) begin
                    bit_idx_r <= bit_idx_r + 4'h1;
                end
            end
        end
    end

    // Shift out MSB first, then the acknowledge slot; sample SDA late in the high phase.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            shift_r <= 9'h1FF;
            rx_shift_r <= 9'h000;
        end else if (launch) begin
            if (cmd_r[ims_pkg::CMD_SEND]) begin
                shift_r <= {char_r, 1'b1};
            end else begin
                shift_r <= {8'hFF, !ACK_SELECT_I};
            end
        end else if (state_r == ims_pkg::ST_BIT && adv) begin
            if (phase_r == 2'h2) begin
                rx_shift_r <= {rx_shift_r[7:0], sda_s2_r};
            end
            if (phase_r == 2'h3) begin
                shift_r <= {shift_r[7:0], 1'b1};
            end
        end
    end

    // Line drive targets; a set enable pulls the wire low, released lines float high.
    always_comb begin
        scl_oe_nxt = scl_oe_r;
        sda_oe_nxt = sda_oe_r;
        case (state_r)
            ims_pkg::ST_START: begin
                case (phase_r)
                    2'h0: sda_oe_nxt = 1'b0;
                    2'h1: scl_oe_nxt = 1'b0;
                    2'h2: sda_oe_nxt = 1'b1;
                    default: scl_oe_nxt = 1'b1;
                endcase
            end
            ims_pkg::ST_STOP: begin
                case (phase_r)
                    2'h0: begin
                        scl_oe_nxt = 1'b1;
                        sda_oe_nxt = 1'b1;
                    end
                    2'h1: scl_oe_nxt = 1'b0;
                    default: sda_oe_nxt = 1'b0;
                endcase
            end
            ims_pkg::ST_BIT: begin
                case (phase_r)
                    2'h0: begin
                        scl_oe_nxt = 1'b1;
                        sda_oe_nxt = !shift_r[8];
                    end
                    2'h3: scl_oe_nxt = 1'b1;
                    default: scl_oe_nxt = 1'b0;
                endcase
            end
            default: begin
                scl_oe_nxt = scl_oe_r;
                sda_oe_nxt = sda_oe_r;
            end
        endcase
    end

    // Open-drain pins: the data value is held low and only the enables move.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            scl_oe_r <= scl_oe_nxt;
            sda_oe_r <= sda_oe_nxt;
        end
    end

    // Command bits: software sets them, the engine clears all of them when a segment finishes, except a bit set in that same cycle.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cmd_r <= ims_pkg::CMD_RST;
        end else if (done) begin
            cmd_r <= ims_pkg::CMD_RST | CMD_SET_I;
        end else begin
            cmd_r <= cmd_r | CMD_SET_I;
        end
    end

    // Sticky completion flags; a completion in the clearing cycle wins.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            flag_r <= ims_pkg::FLG_RST;
        end else begin
            flag_r[ims_pkg::FLG_CMDFIN] <= (flag_r[ims_pkg::FLG_CMDFIN] && !FLAG_CLR_I[ims_pkg::FLG_CMDFIN]) ||
                (done && !is_tx_r && !is_rx_r);
            flag_r[ims_pkg::FLG_TXFIN] <= (flag_r[ims_pkg::FLG_TXFIN] && !FLAG_CLR_I[ims_pkg::FLG_TXFIN]) ||
                (done && is_tx_r);
            flag_r[ims_pkg::FLG_RXFIN] <= (flag_r[ims_pkg::FLG_RXFIN] && !FLAG_CLR_I[ims_pkg::FLG_RXFIN]) ||
                rx_push;
            if (done && is_tx_r) begin
                flag_r[ims_pkg::FLG_NACK] <= rx_shift_r[0];
            end else begin
                flag_r[ims_pkg::FLG_NACK] <= flag_r[ims_pkg::FLG_NACK] && !FLAG_CLR_I[ims_pkg::FLG_NACK];
            end
        end
    end

    // Shared character register; writes are ignored while a segment runs.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            char_r <= ims_pkg::DATA_RST;
        end else if (rx_push) begin
            char_r <= rx_shift_r[8:1];
        end else if (DATA_WR_I && state_r == ims_pkg::ST_IDLE) begin
            char_r <= DATA_I;
        end
    end

    // Busy has its own flop, so the pin shows no glitch while the state register decodes.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= launch || ((state_r != ims_pkg::ST_IDLE) && !done);
        end
    end

    ims_pair_buffer #(
        .WIDTH(8),
        .DEPTH(ims_pkg::RXBUF_DEPTH)
    ) u_rx_buf (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .in_valid_i(rx_push),
        .in_ready_o(buf_ready),
        .in_data_i(rx_shift_r[8:1]),
        .out_valid_o(RX_VALID_O),
        .out_ready_i(RX_READY_I),
        .out_data_o(RX_DATA_O)
    );

    assign CMD_O = cmd_r;
    assign FLAGS_O = flag_r;
    assign DATA_O = char_r;
    assign BUSY_O = busy_r;
    assign SCL_OE_O = scl_oe_r;
    assign SDA_OE_O = sda_oe_r;
    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;

    chk_busy_onehot: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (state_r != ims_pkg::ST_IDLE) |-> $onehot(cmd_r)) else $error("busy without one command bit");
    chk_idle_quiet: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (state_r == ims_pkg::ST_IDLE) && (cmd_r == 4'h0) |=> $stable(scl_oe_r) && $stable(sda_oe_r))
        else $error("bus moved with no segment pending");
    chk_mode_gate: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (state_r == ims_pkg::ST_IDLE) && !mode_ok |=> (state_r == ims_pkg::ST_IDLE))
        else $error("segment started outside two-wire mode");
    chk_cmd_fin: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        done && !is_tx_r && !is_rx_r |=> flag_r[ims_pkg::FLG_CMDFIN] && !BUSY_O)
        else $error("start or stop finished without flag");
    chk_tx_fin: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        $fell(cmd_r[ims_pkg::CMD_SEND]) |-> flag_r[ims_pkg::FLG_TXFIN]) else $error("send cleared without flag");
    chk_rx_fin: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        rx_push |=> flag_r[ims_pkg::FLG_RXFIN] && (char_r == $past(rx_shift_r[8:1])))
        else $error("receive finished without data or flag");
    chk_tx_msb: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (state_r == ims_pkg::ST_BIT) && is_tx_r && bit_idx_r == 4'h0 && phase_r == 2'h2 |->
        sda_oe_r == !char_r[7]) else $error("first sent bit is not the MSB");
    chk_ack_drive: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (state_r == ims_pkg::ST_BIT) && is_rx_r && bit_idx_r == 4'h8 && phase_r == 2'h2 |->
        sda_oe_r == ack_sel_r) else $error("receive acknowledge level wrong");
    chk_nack_rec: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        done && is_tx_r |=> flag_r[ims_pkg::FLG_NACK] == $past(rx_shift_r[0]))
        else $error("acknowledge of transmit not recorded");
    chk_start_edge: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (state_r == ims_pkg::ST_START) && $rose(sda_oe_r) |-> !scl_oe_r) else $error("start without SCL high");
    chk_open_drain: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        done && (state_r == ims_pkg::ST_STOP) |=> !SCL_O && !SDA_O && !scl_oe_r && !sda_oe_r)
        else $error("lines not left to the pull-ups after stop");

    cov_start: cover property (@(posedge CLK_I) disable iff (!RSTN_I) done && state_r == ims_pkg::ST_START);
    cov_send: cover property (@(posedge CLK_I) disable iff (!RSTN_I) done && is_tx_r);
    cov_recv: cover property (@(posedge CLK_I) disable iff (!RSTN_I) rx_push);
    cov_stop: cover property (@(posedge CLK_I) disable iff (!RSTN_I) done && state_r == ims_pkg::ST_STOP);
endmodule

// ### dv/ims_slave_model.sv
// Behavioural two-wire slave that answers the segment engine on the open-drain wires.
`timescale 1ns/1ps
module ims_slave_model #(
    parameter int STRETCH_NS = 200
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic nack_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic stretch_i,
    output logic scl_oe_o,
    output logic sda_oe_o,
    output logic [7:0] rx_byte_o,
    output logic mack_o,
    output int starts_o,
    output int stops_o
);
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic rd_r;
    logic first_r;
    logic lead_r;
    int bit_n;

    // Lines start released, so the pull-ups give both wires a high level.
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
        rx_byte_o = 8'h00;
        mack_o = 1'b0;
        starts_o = 0;
        stops_o = 0;
        bit_n = 0;
        rd_r = 1'b0;
        first_r = 1'b0;
        lead_r = 1'b0;
    end

    // Start and stop are data edges while the clock is high; time zero is skipped to avoid power-up edges.
    always @(negedge sda_i) begin
        if ($time > 0 && scl_i === 1'b1) begin
            starts_o++;
            bit_n = 0;
            rd_r = 1'b0;
            first_r = 1'b1;
            lead_r = 1'b1;
            sda_oe_o = 1'b0;
        end
    end
    always @(posedge sda_i) begin
        if ($time > 0 && scl_i === 1'b1) begin
            stops_o++;
            rd_r = 1'b0;
            first_r = 1'b0;
        end
    end

    // Bits are taken on the rising clock; the first byte's low bit picks the direction.
    always @(posedge scl_i) begin
        if (bit_n < 8) begin
            sh_r = {sh_r[6:0], sda_i};
        end else if (rd_r) begin
            mack_o = sda_i;
            rd_r = !sda_i;
        end else if (first_r) begin
            rd_r = sh_r[0];
            first_r = 1'b0;
        end
        if (bit_n == 7 && !rd_r) rx_byte_o = sh_r;
        bit_n = (bit_n == 8) ? 0 : bit_n + 1;
    end

    // Data changes only while the clock is low; later read bytes are the inverse of the one before.
    always @(negedge scl_i) begin
        if (bit_n == 0 && rd_r) begin
            tx_r = lead_r ? tx_byte_i : ~tx_r;
            lead_r = 1'b0;
        end
        if (bit_n == 8) sda_oe_o = !rd_r && !nack_i;
        else if (rd_r) sda_oe_o = !tx_r[7 - bit_n];
        else sda_oe_o = 1'b0;
        if (stretch_i) begin
            scl_oe_o = 1'b1;
            #(STRETCH_NS) scl_oe_o = 1'b0;
        end
    end
endmodule

// ### dv/ims_segment_master_bench.sv
// Self-checking bench that builds whole frames from single segments against a slave model.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module ims_segment_master_bench;
    localparam int QTR = 4;
    logic clk, rstn, ack_sel, data_wr, rx_ready, nack, stretch, rx_valid, busy;
    logic scl_o, scl_oe, sda_o, sda_oe, s_scl_oe, s_sda_oe, s_mack;
    logic [2:0] mode;
    logic [3:0] cmd_set, flag_clr, cmd, flags;
    logic [7:0] data_in, data_out, rx_data, tx_byte, s_rx;
    int s_starts, s_stops, miscompares, n_compared;
    // Open-drain wires: low while any party pulls, pull-up level otherwise.
    wire scl_w = !(scl_oe === 1'b1 || s_scl_oe === 1'b1);
    wire sda_w = !(sda_oe === 1'b1 || s_sda_oe === 1'b1);

    ims_segment_master #(.QTR_CYCLES_P(QTR)) dut_u (.CLK_I(clk), .RSTN_I(rstn), .MODE_I(mode),
        .CMD_SET_I(cmd_set), .CMD_O(cmd), .ACK_SELECT_I(ack_sel), .FLAG_CLR_I(flag_clr), .FLAGS_O(flags),
        .DATA_WR_I(data_wr), .DATA_I(data_in), .DATA_O(data_out), .RX_VALID_O(rx_valid),
        .RX_READY_I(rx_ready), .RX_DATA_O(rx_data), .BUSY_O(busy), .SCL_I(scl_w), .SCL_O(scl_o),
        .SCL_OE_O(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(sda_oe));
    ims_slave_model slv_u (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack), .tx_byte_i(tx_byte),
        .stretch_i(stretch), .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe), .rx_byte_o(s_rx),
        .mack_o(s_mack), .starts_o(s_starts), .stops_o(s_stops));

    // Free-running system clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // One segment: set its bit, wait for the self-clear, check and clear its finish flag.
    task automatic seg(input int b, input int quarters);
        int n;
        int f;
        n = 0;
        f = (b == ims_pkg::CMD_SEND) ? ims_pkg::FLG_TXFIN :
            (b == ims_pkg::CMD_RECV) ? ims_pkg::FLG_RXFIN : ims_pkg::FLG_CMDFIN;
        @(posedge clk) cmd_set <= 4'(1 << b);
        @(posedge clk) cmd_set <= 4'h0;
        @(negedge clk);
        `CHK("command pending", 1'b1, cmd[b])
        while (cmd[b] !== 1'b0 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        `CHK("command self-cleared", 1'b0, cmd[b])
        `CHK("segment duration", 1'b1, n >= quarters * QTR - 1)
        `CHK("finish flag", 1'b1, flags[f])
        @(posedge clk) flag_clr <= 4'(1 << f);
        @(posedge clk) flag_clr <= 4'h0;
        @(negedge clk);
        `CHK("finish flag cleared", 1'b0, flags[f])
    endtask

    // Loads the shared character register, then transmits it with the given slave answer.
    task automatic send(input logic [7:0] v, input logic nk);
        nack = nk;
        @(posedge clk) data_wr <= 1'b1;
        data_in <= v;
        @(posedge clk) data_wr <= 1'b0;
        @(negedge clk);
        `CHK("char register", v, data_out)
        seg(ims_pkg::CMD_SEND, 36);
        `CHK("byte at slave", v, s_rx)
        `CHK("nack flag", nk, flags[ims_pkg::FLG_NACK])
    endtask

    // Takes one word from the receive buffer once it is offered.
    task automatic pop(input logic [7:0] v);
        int n;
        n = 0;
        while (rx_valid !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        `CHK("buffer head", v, rx_data)
        @(posedge clk) rx_ready <= 1'b1;
        @(posedge clk) rx_ready <= 1'b0;
        @(negedge clk);
    endtask

    task automatic summarize();
        $display("Compared %0d values, %0d mismatches", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Frames are built by software from segments in an allowed order.
    initial begin
        miscompares = 0;
        n_compared = 0;
        {rstn, ack_sel, data_wr, rx_ready, nack, stretch} = 6'h00;
        {cmd_set, flag_clr, data_in, tx_byte} = 24'h000000;
        mode = 3'h1;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        `CHK("reset state", 22'h0, {cmd, flags, data_out, rx_valid, busy, scl_oe, sda_oe, scl_o, sda_o})
        // A start while the function select is wrong must wait untouched.
        @(posedge clk) cmd_set <= 4'h1;
        @(posedge clk) cmd_set <= 4'h0;
        repeat (20) @(negedge clk);
        `CHK("no launch off mode", 4'h7, {busy, cmd[0], scl_w, sda_w})
        `CHK("no start off mode", 0, s_starts)
        @(posedge clk) mode <= ims_pkg::MODE_I2C;
        seg(ims_pkg::CMD_START, 4);
        send(8'hA4, 1'b0);
        send(8'hC3, 1'b0);
        send(8'h5A, 1'b1);
        seg(ims_pkg::CMD_STOP, 4);
        `CHK("stop seen, bus idle", 3'h7, {s_stops == 1, scl_w, sda_w})
        // Ten-bit address, repeated start and reads with both acknowledge levels.
        seg(ims_pkg::CMD_START, 4);
        send(8'hF4, 1'b0);
        send(8'h37, 1'b0);
        tx_byte = 8'h96;
        seg(ims_pkg::CMD_START, 4);
        `CHK("repeated start", 3, s_starts)
        send(8'hF5, 1'b0);
        @(posedge clk) ack_sel <= 1'b1;
        seg(ims_pkg::CMD_RECV, 36);
        `CHK("received char", 9'h12C, {data_out, s_mack})
        seg(ims_pkg::CMD_RECV, 36);
        `CHK("received char", 9'h0D2, {data_out, s_mack})
        // Buffer is full: a third receive waits until a word is taken.
        @(posedge clk) cmd_set <= 4'h4;
        @(posedge clk) cmd_set <= 4'h0;
        repeat (40) @(negedge clk);
        `CHK("receive stalled", 2'h1, {busy, cmd[2]})
        @(posedge clk) ack_sel <= 1'b0;
        stretch = 1'b1;
        pop(8'h96);
        pop(8'h69);
        seg(ims_pkg::CMD_RECV, 30);
        `CHK("nack after char", 9'h12D, {data_out, s_mack})
        pop(8'h96);
        stretch = 1'b0;
        seg(ims_pkg::CMD_STOP, 4);
        `CHK("second stop", 2, s_stops)
        // Two bits at once launch nothing; a reset while idle clears the pending bits.
        @(posedge clk) cmd_set <= 4'h3;
        @(posedge clk) cmd_set <= 4'h0;
        repeat (20) @(negedge clk);
        `CHK("illegal pair idle", 3'h0, {busy, s_starts != 3, s_stops != 2})
        @(posedge clk) rstn <= 1'b0;
        @(negedge clk);
        `CHK("reset clears", 16'h0000, {cmd, flags, data_out})
        @(posedge clk) rstn <= 1'b1;
        // The engine must run a whole frame again straight after a reset with bits pending.
        seg(ims_pkg::CMD_START, 4);
        seg(ims_pkg::CMD_STOP, 4);
        `CHK("frame after reset", 2'h3, {s_starts == 4, s_stops == 3})
        summarize();
    end

    // Guards against a hang; the run needs well under a tenth of this span.
    initial begin
        #300000;
        miscompares++;
        summarize();
    end
endmodule
